// ===== common/torque_monitor_consts.svh
// Constants for the dual channel torque off monitor
`ifndef TORQUE_MONITOR_CONSTS_SVH
`define TORQUE_MONITOR_CONSTS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define RESP_TIME_MS 20
`define CLK_FREQ_MHZ 125
`define WD_W 22
`define SYNC_IDLE 3'h7
// ----------------------------------------
// Fault history codes
// ----------------------------------------
`define CODE_W 7
`define CODE_NONE 7'h00
`define CODE_CH1 7'h48
`define CODE_STO 7'h4c
`define CODE_CH2 7'h4d
`define CODE_INT 7'h4e
`define HIST_DEPTH 6
// ----------------------------------------
// Register map and fields
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_CMD 8'h04
`define ADDR_STATUS 8'h08
`define ADDR_HIST 8'h0c
`define ADDR_NONE 8'hff
`define CTRL_LATCH 0
`define CTRL_RAR 1
`define CMD_RUN 0
`define CMD_RESET 1
`define STAT_IN1 0
`define STAT_IN2 1
`define STAT_RUN 2
`define STAT_TORQUE 3
`define STAT_CODE 8
`endif

// ===== common/torque_monitor_pkg.sv
// Types of the dual channel torque off monitor
package torque_monitor_pkg;
`include "torque_monitor_consts.svh"
	typedef enum logic [2:0] {
		st_ready,
		st_ch1,
		st_ch2,
		st_sto,
		st_int
	} mon_state_t;
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] sd;
		logic in1;
		logic in2;
		logic diag_f;
		mon_state_t state;
		logic running;
		logic armed;
		logic latch_sel;
		logic rar_sel;
		logic run_cmd;
		logic rst_cmd;
		logic [`WD_W-1:0] wd;
		logic [`HIST_DEPTH-1:0][`CODE_W-1:0] hist;
		logic wr_pend;
		logic [7:0] waddr;
		logic [31:0] hrdata;
		logic hready;
		logic hresp;
		logic torque_en;
		logic [`CODE_W-1:0] err_code;
	} mon_regs_t;
endpackage

// ===== rtl/dual_channel_torque_off_monitor.sv
// Dual channel torque off supervisor with AHB-Lite registers
`timescale 1ns/1ps
`include "torque_monitor_consts.svh"
module dual_channel_torque_off_monitor
	import torque_monitor_pkg::*;
#(
	parameter int RESP_CYCLES = `RESP_TIME_MS * 1000 * `CLK_FREQ_MHZ
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Safety inputs, channels high while on; internal_diag_err high on a fault
	input wire logic safety_input_ch1,
	input wire logic safety_input_ch2,
	input wire logic internal_diag_err,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Drive side
	output logic torque_enable,
	output logic [`CODE_W-1:0] error_code
);
	mon_regs_t q;
	mon_regs_t d;
	mon_state_t nst;
	logic wd_hit;
	logic ifault;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [`CODE_W-1:0] code_of(input mon_state_t s);
		logic [`CODE_W-1:0] c;
		c = `CODE_NONE;
		case (s)
			st_ch1: c = `CODE_CH1;
			st_ch2: c = `CODE_CH2;
			st_sto: c = `CODE_STO;
			st_int: c = `CODE_INT;
			default: c = `CODE_NONE;
		endcase
		return c;
	endfunction

	function automatic logic [31:0] rd_word(input logic [7:0] a,
			input mon_regs_t r);
		logic [31:0] w;
		w = 32'h0;
		if (a == `ADDR_CTRL) begin
			w[`CTRL_LATCH] = r.latch_sel;
			w[`CTRL_RAR] = r.rar_sel;
		end else if (a == `ADDR_CMD) begin
			w[`CMD_RUN] = r.run_cmd;
		end else if (a == `ADDR_STATUS) begin
			w[`STAT_IN1] = r.in1;
			w[`STAT_IN2] = r.in2;
			w[`STAT_RUN] = r.running;
			w[`STAT_TORQUE] = r.torque_en;
			w[`STAT_CODE +: `CODE_W] = r.err_code;
		end else begin
			for (int i = 0; i < `HIST_DEPTH; i++) begin
				if (a == `ADDR_HIST + 8'(4 * i)) begin
					w[`CODE_W-1:0] = r.hist[i];
				end
			end
		end
		return w;
	endfunction

	// Backstop: torque still on this long with an input off
	assign wd_hit = q.wd == `WD_W'(RESP_CYCLES - 1);
	assign ifault = q.diag_f | wd_hit;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		d = q;
		nst = q.state;
		d.s1 = {q.s1[1:0], safety_input_ch1};
		d.s2 = {q.s2[1:0], safety_input_ch2};
		d.sd = {q.sd[1:0], internal_diag_err};
		if (q.s1[1] == q.s1[2]) begin
			d.in1 = q.s1[2];
		end
		if (q.s2[1] == q.s2[2]) begin
			d.in2 = q.s2[2];
		end
		if (q.sd[1] == q.sd[2]) begin
			d.diag_f = q.sd[2];
		end
		// Register writes land in the data phase
		d.rst_cmd = 1'b0;
		d.wr_pend = 1'b0;
		if (q.wr_pend) begin
			if (q.waddr == `ADDR_CTRL) begin
				d.latch_sel = hwdata[`CTRL_LATCH];
				d.rar_sel = hwdata[`CTRL_RAR];
			end else if (q.waddr == `ADDR_CMD) begin
				d.run_cmd = hwdata[`CMD_RUN];
				d.rst_cmd = hwdata[`CMD_RESET];
			end
		end
		if (hsel && hready && htrans[1]) begin
			if (hwrite) begin
				d.wr_pend = 1'b1;
				d.waddr = (haddr[31:8] == 24'h0) ? haddr[7:0] : `ADDR_NONE;
			end else if (haddr[31:8] == 24'h0) begin
				d.hrdata = rd_word(haddr[7:0], q);
			end else begin
				d.hrdata = 32'h0;
			end
		end
		d.hready = 1'b1;
		d.hresp = 1'b0;
		if (q.torque_en && !(q.in1 && q.in2) && !wd_hit) begin
			d.wd = q.wd + `WD_W'(1);
		end else if (!q.torque_en) begin
			d.wd = '0;
		end
		case (q.state)
			st_ready: begin
				if (ifault) begin
					nst = st_int;
				end else if (!q.in1 && q.in2) begin
					nst = st_ch1;
				end else if (q.in1 && !q.in2) begin
					nst = st_ch2;
				end else if (!q.in1 && !q.in2) begin
					nst = st_sto;
				end
				// Standby until a fresh run command
				if (!q.run_cmd) begin
					d.running = 1'b0;
					d.armed = 1'b1;
				end else if (q.armed) begin
					d.running = 1'b1;
				end
			end
			st_sto: begin
				if (ifault) begin
					nst = st_int;
				// Clear by reset or by latch select
				end else if (q.in1 && q.in2 &&
						(q.latch_sel || q.rst_cmd)) begin
					nst = st_ready;
					// Resume only with run still present
					d.running = q.rar_sel && q.run_cmd;
				end
			end
			st_ch1, st_ch2: begin
				if (ifault) begin
					nst = st_int;
				end
			end
			default: begin
				nst = st_int;
			end
		endcase
		if (nst != st_ready) begin
			d.running = 1'b0;
			d.armed = 1'b0;
		end
		d.state = nst;
		// Log each fault entry, newest first
		if (nst != q.state && nst != st_ready) begin
			d.hist = {q.hist[`HIST_DEPTH-2:0], code_of(nst)};
		end
		d.torque_en = (nst == st_ready) && d.running;
		d.err_code = code_of(nst);
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q <= '0;
			// Channel filters start at the on level, diag filter at no fault: no false torque off at release
			q.s1 <= `SYNC_IDLE;
			q.s2 <= `SYNC_IDLE;
			q.in1 <= 1'b1;
			q.in2 <= 1'b1;
			q.state <= st_ready;
			q.hready <= 1'b1;
			q.waddr <= `ADDR_NONE;
		end else begin
			q <= d;
		end
	end

	assign hrdata = q.hrdata;
	assign hreadyout = q.hready;
	assign hresp = q.hresp;
	assign torque_enable = q.torque_en;
	assign error_code = q.err_code;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_sto_entry: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && !q.in1 && !q.in2 && !ifault) |=>
		(q.state == st_sto && !q.torque_en && q.err_code == `CODE_STO))
		else $error("torque off state not entered");
	a_ch1_entry: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && !q.in1 && q.in2 && !ifault) |=>
		(q.state == st_ch1 && !q.torque_en))
		else $error("channel 1 fault not entered");
	a_ch2_entry: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && q.in1 && !q.in2 && !ifault) |=>
		(q.state == st_ch2 && !q.torque_en))
		else $error("channel 2 fault not entered");
	a_ready_clean: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready) |->
		(q.err_code == `CODE_NONE && q.torque_en == q.running))
		else $error("standby shows error or wrong output");
	a_resp_bound: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(q.in1 && q.in2) |-> ##[0:1] !q.torque_en)
		else $error("torque not removed in time");
	a_int_fault: assert property (@(posedge clk) disable iff (!rst_b)
		q.diag_f |=> (q.state == st_int && q.err_code == `CODE_INT))
		else $error("internal loop fault not raised");
	a_hist_log: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && !q.in1 && q.in2 && !ifault) |=>
		(q.hist[0] == `CODE_CH1 && q.hist[1] == $past(q.hist[0])))
		else $error("fault history not shifted");
	a_sto_reset: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_sto && q.in1 && q.in2 && q.rst_cmd && !ifault)
		|=> q.state == st_ready)
		else $error("reset did not clear torque off");
	a_ch_latched: assert property (@(posedge clk) disable iff (!rst_b)
		((q.state == st_ch1 || q.state == st_ch2) && !ifault) |=>
		$stable(q.state))
		else $error("channel fault left without power cycle");
	a_sto_latch: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_sto && !ifault && !q.latch_sel && !q.rst_cmd)
		|=> q.state == st_sto)
		else $error("latched torque off cleared alone");
	a_sto_auto: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_sto && !ifault && q.latch_sel && q.in1 && q.in2)
		|=> q.state == st_ready)
		else $error("unlatched torque off not cleared");
	a_rar_resume: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_sto && q.in1 && q.in2 && q.rst_cmd && !ifault)
		|=> q.running == $past(q.rar_sel && q.run_cmd))
		else $error("wrong run state after clear");
	a_sync_filter: assert property (@(posedge clk) disable iff (!rst_b)
		(q.s1[1] != q.s1[2]) |=> $stable(q.in1))
		else $error("channel 1 changed on a disagreement");
	a_int_prec: assert property (@(posedge clk) disable iff (!rst_b)
		(ifault && q.state != st_ready) |=> q.state == st_int)
		else $error("internal fault lost precedence");
	a_sync_ch2: assert property (@(posedge clk) disable iff (!rst_b)
		(q.s2[1] != q.s2[2]) |=> $stable(q.in2))
		else $error("channel 2 changed on a disagreement");
	a_run_blocked: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && q.run_cmd && !(q.in1 && q.in2)) |=>
		!q.torque_en)
		else $error("output kept on with an input off");
	a_sto_hist: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && !q.in1 && !q.in2 && !ifault) |=>
		q.hist[0] == `CODE_STO)
		else $error("torque off not logged");
	a_ch2_hist: assert property (@(posedge clk) disable iff (!rst_b)
		(q.state == st_ready && q.in1 && !q.in2 && !ifault) |=>
		q.hist[0] == `CODE_CH2)
		else $error("channel 2 fault not logged");
	a_int_stays: assert property (@(posedge clk) disable iff (!rst_b)
		q.state == st_int |=> q.state == st_int)
		else $error("internal loop fault left without power cycle");
endmodule

// ===== sim/estop_switch.sv
// Emergency stop switch model driving both safety channels
`timescale 1ns/1ps
module estop_switch (
	// Contact requests, high opens the contact
	input wire logic open1,
	input wire logic open2,
	// Safety lines, high while the contact is closed
	output logic ch1,
	output logic ch2
);
	// ----------------------------------------
	// Contacts
	// ----------------------------------------
	// Lines are always driven, never left floating
	// Restore before reset
	assign ch1 = !open1;
	assign ch2 = !open2;
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the torque off monitor
`timescale 1ns/1ps
`include "torque_monitor_consts.svh"
module testbench;
	import torque_monitor_pkg::*;
	logic clk, rst_b, diag, hsel, hwrite, open1, open2, ch1, ch2;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic hreadyout, hresp, torque_enable;
	logic [6:0] error_code;
	wire hready;
	int bad_count, check_count;
	assign hready = hreadyout;
	// ----------------------------------------
	// Device and switch
	// ----------------------------------------
	// Short watchdog span keeps any stuck torque visible
	dual_channel_torque_off_monitor #(.RESP_CYCLES(16)) u_dut (
		.clk(clk), .rst_b(rst_b),
		.safety_input_ch1(ch1), .safety_input_ch2(ch2),
		.internal_diag_err(diag),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.torque_enable(torque_enable), .error_code(error_code)
	);
	estop_switch u_switch (.open1(open1), .open2(open2), .ch1(ch1),
		.ch2(ch2));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask
	// Input path settles in five cycles, eight leaves margin
	task automatic st(input logic [6:0] c, input logic t);
		wt(8);
		chk({25'h0, error_code}, {25'h0, c});
		chk({31'h0, torque_enable}, {31'h0, t});
	endtask
	task automatic pwr;
		rst_b <= 1'b0;
		wt(2);
		rst_b <= 1'b1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		wt(5000);
		bad_count++;
		wrap_up;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		rst_b = 1'b0;
		diag = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		hsize = 3'h2;
		haddr = 32'h0;
		hwdata = 32'h0;
		open1 = 1'b0;
		open2 = 1'b0;
		bad_count = 0;
		check_count = 0;
		wt(6);
		rst_b <= 1'b1;
		st(`CODE_NONE, 1'b0);
		bus(1'b1, `ADDR_CMD, 32'h1);
		st(`CODE_NONE, 1'b1);
		open1 <= 1'b1;
		open2 <= 1'b1;
		st(`CODE_STO, 1'b0);
		bus(1'b0, `ADDR_HIST, 32'h0);
		chk(rd, 32'h4c);
		open1 <= 1'b0;
		open2 <= 1'b0;
		st(`CODE_STO, 1'b0);
		bus(1'b1, `ADDR_CMD, 32'h3);
		st(`CODE_NONE, 1'b0);
		bus(1'b1, `ADDR_CTRL, 32'h2);
		bus(1'b1, `ADDR_CMD, 32'h0);
		bus(1'b1, `ADDR_CMD, 32'h1);
		st(`CODE_NONE, 1'b1);
		open1 <= 1'b1;
		open2 <= 1'b1;
		st(`CODE_STO, 1'b0);
		open1 <= 1'b0;
		open2 <= 1'b0;
		st(`CODE_STO, 1'b0);
		bus(1'b1, `ADDR_CMD, 32'h3);
		st(`CODE_NONE, 1'b1);
		bus(1'b1, `ADDR_CTRL, 32'h1);
		open1 <= 1'b1;
		open2 <= 1'b1;
		st(`CODE_STO, 1'b0);
		open1 <= 1'b0;
		open2 <= 1'b0;
		st(`CODE_NONE, 1'b0);
		open1 <= 1'b1;
		st(`CODE_CH1, 1'b0);
		open1 <= 1'b0;
		st(`CODE_CH1, 1'b0);
		bus(1'b1, `ADDR_CMD, 32'h3);
		st(`CODE_CH1, 1'b0);
		bus(1'b0, `ADDR_HIST, 32'h0);
		chk(rd, 32'h48);
		bus(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h4c);
		pwr;
		st(`CODE_NONE, 1'b0);
		open2 <= 1'b1;
		st(`CODE_CH2, 1'b0);
		open2 <= 1'b0;
		st(`CODE_CH2, 1'b0);
		bus(1'b1, `ADDR_CMD, 32'h2);
		st(`CODE_CH2, 1'b0);
		open2 <= 1'b1;
		pwr;
		st(`CODE_CH2, 1'b0);
		open2 <= 1'b0;
		pwr;
		st(`CODE_NONE, 1'b0);
		open1 <= 1'b1;
		diag <= 1'b1;
		st(`CODE_INT, 1'b0);
		bus(1'b0, `ADDR_STATUS, 32'h0);
		chk(rd, {17'h0, `CODE_INT, 8'h02});
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0);
		wrap_up;
	end
endmodule
